// >>> core/dbgbp_pkg.sv
// Purpose: Shared constants for the debug breakpoint unit.
// Assumes: One core clock; the execution core drives all requests.
// Notes: Register indices follow the debug register numbering 0 to 7.
// Operation
// - Debug registers are 32 bits wide.
// - Four breakpoint addresses compared against every cycle.
// - Extension off: alias 5/4 reach control/status.
// - Extension on: alias 5/4 access is undefined-opcode.
// - Hit flags set always; exception only if enabled.
// - Guarded register access sets flag 13, faults.
// - Trap flag: step trap after each instruction.
// - Task trap bit set: flag 15, debug exception.
// - Local enables cleared on every task switch.
// - Global enables survive switches, override local.
// - Compatibility bits 8, 9 stored, no effect.
// - Guard bit enables access fault, cleared on debug exception.
// - Two-bit type and size fields per breakpoint.
// - Data, I/O, step, task events trap on 01h.
// - Execution breakpoints, access flag fault on 01h.
// - Opcode CCh traps on vector 03h after execution when no 01h cause shares the cycle.
package dbgbp_pkg;
   // ---------------------------------------------------------------------
   // Register indices and widths.
   // ---------------------------------------------------------------------
   localparam int unsigned DW = 32;
   localparam logic [2:0] IDX_STAT_ALIAS = 3'h4;
   localparam logic [2:0] IDX_CTRL_ALIAS = 3'h5;
   localparam logic [2:0] IDX_STAT = 3'h6;
   localparam logic [2:0] IDX_CTRL = 3'h7;
   localparam logic [31:0] ADDR_RST = 32'h0000_0000;
   localparam logic [31:0] STAT_RST = 32'h0000_0000;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   // ---------------------------------------------------------------------
   // Field positions.
   // ---------------------------------------------------------------------
   localparam int unsigned ST_REG_ACCESS = 13;
   localparam int unsigned ST_SINGLE_STEP = 14;
   localparam int unsigned ST_TASK_SWITCH = 15;
   localparam int unsigned CT_COMPAT_LOCAL = 8;
   localparam int unsigned CT_COMPAT_GLOBAL = 9;
   localparam int unsigned CT_GUARD = 13;
   localparam int unsigned CT_FIELD_BASE = 16;
   localparam int unsigned CT_FIELD_STRIDE = 4;
   localparam int unsigned CR4_DBG_EXT = 3;
   localparam int unsigned FLAGS_TRAP = 8;
   localparam logic [31:0] STAT_WMASK = 32'h0000_E00F;
   localparam logic [31:0] CTRL_WMASK = 32'hFFFF_23FF;
   // ---------------------------------------------------------------------
   // Type codes, vectors and opcodes.
   // ---------------------------------------------------------------------
   localparam logic [1:0] TYPE_EXEC = 2'h0;
   localparam logic [1:0] TYPE_WRITE = 2'h1;
   localparam logic [1:0] TYPE_IO = 2'h2;
   localparam logic [1:0] TYPE_RDWR = 2'h3;
   localparam logic [7:0] VEC_DEBUG = 8'h01;
   localparam logic [7:0] VEC_BREAK = 8'h03;
   localparam logic [7:0] OPC_BREAK = 8'hCC;
endpackage

// >>> core/dbgbp_unit.sv
// Purpose: Debug breakpoint registers, matching and exception requests.
// Assumes: All inputs come from core logic on CLK; no synchronisers needed.
// Notes: Exception requests are one-cycle pulses registered off the cause.
`timescale 1ns/1ps
module dbgbp_unit #(
   parameter int unsigned NBP = 4
)(
   // Clock and reset.
   input logic CLK,
   input logic RST_N,
   // Debug register move requests from the decoder.
   input logic REG_WR,
   input logic REG_RD,
   input logic [2:0] REG_IDX,
   input logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA,
   output logic REG_RVALID,
   // Architectural state from the core.
   input logic [31:0] CTRL_REG_FOUR,
   input logic [31:0] FLAGS_WORD,
   // Instruction fetch about to execute.
   input logic INSN_VALID,
   input logic [31:0] INSN_LADDR,
   // Instruction retired successfully.
   input logic RETIRE,
   input logic [7:0] RETIRE_OPCODE,
   // Data or I/O cycle.
   input logic DCYC_VALID,
   input logic [31:0] DCYC_ADDR,
   input logic [1:0] DCYC_SIZE,
   input logic DCYC_WRITE,
   input logic DCYC_IO,
   // Task switch.
   input logic TSW,
   input logic TSW_TRAP,
   // Exception requests.
   output logic EXC_VALID,
   output logic [7:0] EXC_VECTOR,
   output logic EXC_FAULT,
   output logic UD_EXC
);

   // ---------------------------------------------------------------------
   // Functions.
   // ---------------------------------------------------------------------

   // Overlap of an access with the size-aligned breakpoint range.
   function automatic logic bp_overlap(input logic [31:0] bp, input logic [1:0] len,
                                       input logic [31:0] a, input logic [1:0] sz);
      logic [32:0] b_lo;
      logic [32:0] b_hi;
      logic [32:0] a_lo;
      logic [32:0] a_hi;
      b_lo = {1'b0, bp & ~{30'h0, len}};
      b_hi = b_lo + {31'h0, len};
      a_lo = {1'b0, a};
      a_hi = a_lo + {31'h0, sz};
      return (a_lo <= b_hi) && (b_lo <= a_hi);
   endfunction

   // Folds the alias indices onto status and control when extensions are off.
   function automatic logic [2:0] map_idx(input logic [2:0] idx);
      logic [2:0] r;
      r = idx;
      if (idx == dbgbp_pkg::IDX_STAT_ALIAS)
      begin
         r = dbgbp_pkg::IDX_STAT;
      end
      else if (idx == dbgbp_pkg::IDX_CTRL_ALIAS)
      begin
         r = dbgbp_pkg::IDX_CTRL;
      end
      return r;
   endfunction

   // ---------------------------------------------------------------------
   // Storage.
   // ---------------------------------------------------------------------
   logic [dbgbp_pkg::DW-1:0] bp_addr_q [NBP];
   logic [31:0] stat_q;
   logic [31:0] ctrl_q;
   logic [31:0] rdata_q;
   logic rvalid_q;
   logic exc_valid_q;
   logic [7:0] exc_vec_q;
   logic exc_fault_q;
   logic ud_q;

   // ---------------------------------------------------------------------
   // Decode of register moves.
   // ---------------------------------------------------------------------
   logic ext_en;
   logic acc_req;
   logic guard_fault;
   logic alias_sel;
   logic ud_hit;
   logic acc_ok;
   logic [2:0] eidx;

   // A guarded move faults first; an alias move with extensions on is undefined.
   always_comb
   begin
      ext_en = CTRL_REG_FOUR[dbgbp_pkg::CR4_DBG_EXT];
      acc_req = REG_WR | REG_RD;
      guard_fault = acc_req & ctrl_q[dbgbp_pkg::CT_GUARD];
      alias_sel = (REG_IDX == dbgbp_pkg::IDX_STAT_ALIAS) || (REG_IDX == dbgbp_pkg::IDX_CTRL_ALIAS);
      ud_hit = acc_req & ~guard_fault & alias_sel & ext_en;
      acc_ok = acc_req & ~guard_fault & ~ud_hit;
      eidx = ext_en ? REG_IDX : map_idx(REG_IDX);
   end

   // ---------------------------------------------------------------------
   // Breakpoint matching.
   // ---------------------------------------------------------------------
   logic [NBP-1:0] ins_hit;
   logic [NBP-1:0] dat_hit;
   logic [NBP-1:0] bp_en;
   logic [1:0] bp_type [NBP];
   logic [1:0] bp_len [NBP];

   // Every breakpoint is compared; enables only gate the exception.
   always_comb
   begin
      for (int i = 0; i < NBP; i++)
      begin
         bp_type[i] = ctrl_q[dbgbp_pkg::CT_FIELD_BASE + i*dbgbp_pkg::CT_FIELD_STRIDE +: 2];
         bp_len[i] = ctrl_q[dbgbp_pkg::CT_FIELD_BASE + i*dbgbp_pkg::CT_FIELD_STRIDE + 2 +: 2];
         bp_en[i] = ctrl_q[2*i] | ctrl_q[2*i+1];
         ins_hit[i] = INSN_VALID && (bp_type[i] == dbgbp_pkg::TYPE_EXEC)
                      && (INSN_LADDR == bp_addr_q[i]);
         dat_hit[i] = 1'b0;
         if (DCYC_VALID && bp_overlap(bp_addr_q[i], bp_len[i], DCYC_ADDR, DCYC_SIZE))
         begin
            case (bp_type[i])
               dbgbp_pkg::TYPE_WRITE: dat_hit[i] = DCYC_WRITE & ~DCYC_IO;
               dbgbp_pkg::TYPE_RDWR: dat_hit[i] = ~DCYC_IO;
               dbgbp_pkg::TYPE_IO: dat_hit[i] = DCYC_IO & ext_en;
               default: dat_hit[i] = 1'b0;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------------
   // Exception causes.
   // ---------------------------------------------------------------------
   logic ins_fault;
   logic dat_trap;
   logic step;
   logic tsw_trap;
   logic brk;
   logic dbg_fault;
   logic dbg_trap;

   // Faults take priority over traps; the breakpoint instruction comes last.
   always_comb
   begin
      ins_fault = |(ins_hit & bp_en);
      dat_trap = |(dat_hit & bp_en);
      step = RETIRE & FLAGS_WORD[dbgbp_pkg::FLAGS_TRAP];
      tsw_trap = TSW & TSW_TRAP;
      brk = RETIRE && (RETIRE_OPCODE == dbgbp_pkg::OPC_BREAK);
      dbg_fault = ins_fault | guard_fault;
      dbg_trap = dat_trap | step | tsw_trap;
   end

   // ---------------------------------------------------------------------
   // Breakpoint address registers.
   // ---------------------------------------------------------------------

   // Written by a permitted move to indices 0 to 3.
   always_ff @(posedge CLK)
   begin
      for (int i = 0; i < NBP; i++)
      begin
         if (!RST_N)
         begin
            bp_addr_q[i] <= dbgbp_pkg::ADDR_RST;
         end
         else if (REG_WR && acc_ok && (eidx == 3'(i)))
         begin
            bp_addr_q[i] <= REG_WDATA;
         end
      end
   end

   // ---------------------------------------------------------------------
   // Status register.
   // ---------------------------------------------------------------------
   logic [31:0] stat_d;
   logic [31:0] stat_set;

   // Hardware sets win over a software write in the same cycle.
   always_comb
   begin
      stat_set = 32'h0000_0000;
      stat_set[NBP-1:0] = ins_hit | dat_hit;
      stat_set[dbgbp_pkg::ST_REG_ACCESS] = guard_fault;
      stat_set[dbgbp_pkg::ST_SINGLE_STEP] = step;
      stat_set[dbgbp_pkg::ST_TASK_SWITCH] = tsw_trap;
      stat_d = stat_q;
      if (REG_WR && acc_ok && (eidx == dbgbp_pkg::IDX_STAT))
      begin
         stat_d = REG_WDATA & dbgbp_pkg::STAT_WMASK;
      end
      stat_d = stat_d | stat_set;
   end

   // Status state update.
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         stat_q <= dbgbp_pkg::STAT_RST;
      end
      else
      begin
         stat_q <= stat_d;
      end
   end

   // ---------------------------------------------------------------------
   // Control register.
   // ---------------------------------------------------------------------
   logic [31:0] ctrl_d;

   // Software write first, then hardware clears of local enables and guard.
   always_comb
   begin
      ctrl_d = ctrl_q;
      if (REG_WR && acc_ok && (eidx == dbgbp_pkg::IDX_CTRL))
      begin
         ctrl_d = REG_WDATA & dbgbp_pkg::CTRL_WMASK;
      end
      if (TSW)
      begin
         for (int i = 0; i < NBP; i++)
         begin
            ctrl_d[2*i] = 1'b0;
         end
      end
      if (dbg_fault | dbg_trap)
      begin
         ctrl_d[dbgbp_pkg::CT_GUARD] = 1'b0;
      end
   end

   // Control state update.
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         ctrl_q <= dbgbp_pkg::CTRL_RST;
      end
      else
      begin
         ctrl_q <= ctrl_d;
      end
   end

   // ---------------------------------------------------------------------
   // Read path.
   // ---------------------------------------------------------------------

   // A permitted read answers on the next edge with the register value.
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         rdata_q <= 32'h0000_0000;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= REG_RD & acc_ok;
         if (REG_RD && acc_ok)
         begin
            case (eidx)
               dbgbp_pkg::IDX_STAT: rdata_q <= stat_q;
               dbgbp_pkg::IDX_CTRL: rdata_q <= ctrl_q;
               default: rdata_q <= (eidx < 3'(NBP)) ? bp_addr_q[eidx[1:0]] : 32'h0000_0000;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------------
   // Exception outputs.
   // ---------------------------------------------------------------------

   // One request per cycle, registered, with vector and fault/trap class.
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         exc_valid_q <= 1'b0;
         exc_vec_q <= 8'h00;
         exc_fault_q <= 1'b0;
         ud_q <= 1'b0;
      end
      else
      begin
         ud_q <= ud_hit;
         exc_valid_q <= dbg_fault | dbg_trap | brk;
         exc_fault_q <= dbg_fault;
         if (dbg_fault | dbg_trap)
         begin
            exc_vec_q <= dbgbp_pkg::VEC_DEBUG;
         end
         else if (brk)
         begin
            exc_vec_q <= dbgbp_pkg::VEC_BREAK;
         end
      end
   end

   // Output drive.
   assign REG_RDATA = rdata_q;
   assign REG_RVALID = rvalid_q;
   assign EXC_VALID = exc_valid_q;
   assign EXC_VECTOR = exc_vec_q;
   assign EXC_FAULT = exc_fault_q;
   assign UD_EXC = ud_q;

endmodule

// >>> bench/dbgbp_unit_asserts.sv
// Purpose: Port checks for the debug breakpoint unit.
// Assumes: One core clock, synchronous active-low reset.
// Notes: Bound to every dbgbp_unit instance.
`timescale 1ns/1ps
module dbgbp_unit_asserts #(
   parameter int unsigned NBP = 4
)(
   // Clock and reset.
   input logic CLK,
   input logic RST_N,
   // Requests.
   input logic REG_WR,
   input logic REG_RD,
   input logic [2:0] REG_IDX,
   input logic [31:0] CTRL_REG_FOUR,
   input logic [31:0] FLAGS_WORD,
   input logic INSN_VALID,
   input logic RETIRE,
   input logic [7:0] RETIRE_OPCODE,
   input logic DCYC_VALID,
   input logic TSW,
   input logic TSW_TRAP,
   // Answers.
   input logic REG_RVALID,
   input logic EXC_VALID,
   input logic [7:0] EXC_VECTOR,
   input logic EXC_FAULT,
   input logic UD_EXC
);
   // All checks sample on the core clock and sleep in reset.
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   a_read_answer: assert property (REG_RVALID |-> $past(REG_RD))
      else $error("read data without a read move");
   a_ud_cause: assert property (UD_EXC |-> $past(REG_IDX[2:1] == 2'h2 && CTRL_REG_FOUR[3]))
      else $error("undefined opcode without an alias move");
   a_ud_de_off: assert property ((REG_RD || REG_WR) && !CTRL_REG_FOUR[3] |=> !UD_EXC)
      else $error("undefined opcode with extension off");
   a_brk_trap: assert property (EXC_VALID && EXC_VECTOR == 8'h03 |-> !EXC_FAULT && $past(RETIRE_OPCODE == 8'hCC))
      else $error("breakpoint vector without its opcode");
   a_step_trap: assert property (RETIRE && FLAGS_WORD[8] |=> EXC_VALID && EXC_VECTOR == 8'h01)
      else $error("single step gave no debug exception");
   a_task_trap: assert property (TSW && TSW_TRAP |=> EXC_VALID && EXC_VECTOR == 8'h01)
      else $error("task trap gave no debug exception");
   a_fault_cause: assert property (EXC_VALID && EXC_FAULT |-> $past(INSN_VALID || REG_RD || REG_WR))
      else $error("fault without fetch or move");
   a_trap_cause: assert property (EXC_VALID && !EXC_FAULT |-> $past(RETIRE || DCYC_VALID || TSW))
      else $error("trap without retire, data cycle or switch");
endmodule
bind dbgbp_unit dbgbp_unit_asserts #(.NBP(NBP)) u_dbgbp_unit_asserts (.CLK(CLK), .RST_N(RST_N),
   .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_IDX(REG_IDX), .CTRL_REG_FOUR(CTRL_REG_FOUR),
   .FLAGS_WORD(FLAGS_WORD), .INSN_VALID(INSN_VALID), .RETIRE(RETIRE), .RETIRE_OPCODE(RETIRE_OPCODE),
   .DCYC_VALID(DCYC_VALID), .TSW(TSW), .TSW_TRAP(TSW_TRAP), .REG_RVALID(REG_RVALID),
   .EXC_VALID(EXC_VALID), .EXC_VECTOR(EXC_VECTOR), .EXC_FAULT(EXC_FAULT), .UD_EXC(UD_EXC));

// >>> bench/dbgbp_core_model.sv
// Purpose: Execution core model driving the debug unit.
// Assumes: Requests change on the falling edge and last one cycle.
// Notes: Released data and address buses show the inverse of their last value; index, size and opcode hold.
`timescale 1ns/1ps
module dbgbp_core_model (
   // Clock.
   input logic CLK,
   // Register moves.
   output logic REG_WR,
   output logic REG_RD,
   output logic [2:0] REG_IDX,
   output logic [31:0] REG_WDATA,
   // Core state.
   output logic [31:0] CTRL_REG_FOUR,
   output logic [31:0] FLAGS_WORD,
   // Events.
   output logic INSN_VALID,
   output logic [31:0] INSN_LADDR,
   output logic RETIRE,
   output logic [7:0] RETIRE_OPCODE,
   output logic DCYC_VALID,
   output logic [31:0] DCYC_ADDR,
   output logic [1:0] DCYC_SIZE,
   output logic DCYC_WRITE,
   output logic DCYC_IO,
   output logic TSW,
   output logic TSW_TRAP
);
   // Idle values from time zero.
   initial
   begin
      {REG_WR, REG_RD, INSN_VALID, RETIRE, DCYC_VALID, TSW, DCYC_IO} = 7'h00;
      {DCYC_WRITE, TSW_TRAP, REG_IDX, DCYC_SIZE, RETIRE_OPCODE} = 15'h6000;
      {REG_WDATA, CTRL_REG_FOUR, FLAGS_WORD, INSN_LADDR, DCYC_ADDR} = 160'h0;
   end
   // One register move lasting one cycle.
   task automatic mov(input logic w, input logic [2:0] i, input logic [31:0] d);
      @(negedge CLK);
      {REG_WR, REG_RD, REG_IDX, REG_WDATA} = {w, !w, i, d};
      @(negedge CLK);
      {REG_WR, REG_RD, REG_WDATA} = {2'h0, ~d};
   endtask
   // Extension enable and trap flag levels.
   task automatic st(input logic de, input logic tf);
      CTRL_REG_FOUR = {28'h0, de, 3'h0};
      FLAGS_WORD = {23'h0, tf, 8'h00};
   endtask
   // Data cycle kind and the next task's trap bit, held as levels between pulses.
   task automatic cyc(input logic w, input logic io, input logic tt);
      DCYC_WRITE = w;
      DCYC_IO = io;
      TSW_TRAP = tt;
   endtask
   // One event pulse: fetch, retire, data cycle, task switch.
   task automatic evt(input logic [3:0] k, input logic [31:0] a, input logic [1:0] sz, input logic [7:0] op);
      @(negedge CLK);
      {INSN_VALID, RETIRE, DCYC_VALID, TSW} = k;
      {INSN_LADDR, DCYC_ADDR, DCYC_SIZE, RETIRE_OPCODE} = {a, a, sz, op};
      @(negedge CLK);
      {INSN_VALID, RETIRE, DCYC_VALID, TSW} = 4'h0;
      {INSN_LADDR, DCYC_ADDR} = {~a, ~a};
   endtask
endmodule

// >>> bench/dbgbp_unit_bench.sv
// Purpose: Self-checking bench for the debug breakpoint unit.
// Assumes: The core model makes all requests.
// Notes: Answers are checked in order against a queue of notes.
`timescale 1ns/1ps
module dbgbp_unit_bench;
   logic clk, rst_n, reg_wr, reg_rd, insn_valid, retire, dcyc_valid, dcyc_write, dcyc_io, tsw, tsw_trap;
   logic [2:0] reg_idx;
   logic [1:0] dcyc_size;
   logic [7:0] retire_op, exc_vector;
   logic [31:0] reg_wdata, cr4, flags, insn_laddr, dcyc_addr, reg_rdata, a;
   logic reg_rvalid, exc_valid, exc_fault, ud_exc;
   logic [33:0] q[$];
   logic [33:0] got;
   int num_errors, n_checks;
   localparam logic [31:0] TRAP = 32'h0000_0001;
   localparam logic [31:0] FLT = 32'h0000_0101;
   dbgbp_unit #(.NBP(4)) u_dbgbp_unit (.CLK(clk), .RST_N(rst_n), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_IDX(reg_idx), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
      .CTRL_REG_FOUR(cr4), .FLAGS_WORD(flags), .INSN_VALID(insn_valid), .INSN_LADDR(insn_laddr),
      .RETIRE(retire), .RETIRE_OPCODE(retire_op), .DCYC_VALID(dcyc_valid), .DCYC_ADDR(dcyc_addr),
      .DCYC_SIZE(dcyc_size), .DCYC_WRITE(dcyc_write), .DCYC_IO(dcyc_io), .TSW(tsw), .TSW_TRAP(tsw_trap),
      .EXC_VALID(exc_valid), .EXC_VECTOR(exc_vector), .EXC_FAULT(exc_fault), .UD_EXC(ud_exc));
   dbgbp_core_model u_dbgbp_core_model (.CLK(clk), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_IDX(reg_idx),
      .REG_WDATA(reg_wdata), .CTRL_REG_FOUR(cr4), .FLAGS_WORD(flags), .INSN_VALID(insn_valid),
      .INSN_LADDR(insn_laddr), .RETIRE(retire), .RETIRE_OPCODE(retire_op), .DCYC_VALID(dcyc_valid),
      .DCYC_ADDR(dcyc_addr), .DCYC_SIZE(dcyc_size), .DCYC_WRITE(dcyc_write), .DCYC_IO(dcyc_io),
      .TSW(tsw), .TSW_TRAP(tsw_trap));
   // Clock at 8 ns.
   initial
   begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   // A move; class 1 notes read data, class 3 an undefined opcode.
   task automatic mv(input logic [1:0] c, input logic [31:0] e, input logic w, input logic [2:0] i,
                     input logic [31:0] d);
      if (c != 2'h0) q.push_back({c, e});
      u_dbgbp_core_model.mov(w, i, d);
   endtask
   // An event; class 2 notes {fault, vector}.
   task automatic ev(input logic [1:0] c, input logic [31:0] e, input logic [3:0] k, input logic [31:0] ad,
                     input logic [1:0] sz, input logic [7:0] op);
      if (c != 2'h0) q.push_back({c, e});
      u_dbgbp_core_model.evt(k, ad, sz, op);
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Compares each answer with the oldest note.
   always @(negedge clk)
   begin
      if (rst_n && (reg_rvalid || exc_valid || ud_exc))
      begin
         got = reg_rvalid ? {2'h1, reg_rdata} : exc_valid ? {2'h2, 23'h0, exc_fault, exc_vector} : {2'h3, 32'h0};
         n_checks++;
         if (q.size() == 0 || q[0] !== got)
         begin
            $display("unexpected answer: expected %h seen %h", q.size() ? q[0] : 34'h0, got);
            num_errors++;
         end
         if (q.size() != 0) void'(q.pop_front());
      end
   end
   // Main sequence.
   initial
   begin
      rst_n = 1'h0;
      num_errors = 0;
      n_checks = 0;
      void'($urandom(91381));
      repeat (20) @(negedge clk);
      rst_n = 1'h1;
      for (int i = 0; i < 8; i++) mv(2'h1, 32'h0, 1'h0, i[2:0], 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         a = $urandom;
         mv(2'h0, 32'h0, 1'h1, i[2:0], a);
         mv(2'h1, a, 1'h0, i[2:0], 32'h0);
      end
      mv(2'h0, 32'h0, 1'h1, 3'h5, 32'h0000_DF00);
      mv(2'h1, 32'h0000_0300, 1'h0, 3'h7, 32'h0);
      $display("test registers done");
      u_dbgbp_core_model.st(1'h1, 1'h0);
      mv(2'h3, 32'h0, 1'h0, 3'h4, 32'h0);
      mv(2'h3, 32'h0, 1'h1, 3'h5, 32'hFFFF_FFFF);
      u_dbgbp_core_model.st(1'h0, 1'h0);
      mv(2'h1, 32'h0000_0300, 1'h0, 3'h7, 32'h0);
      $display("test aliases done");
      // Four-byte write breakpoint 0, no I/O type, no size 10b.
      mv(2'h0, 32'h0, 1'h1, 3'h0, 32'h0000_1000);
      mv(2'h0, 32'h0, 1'h1, 3'h7, 32'h000D_0000);
      mv(2'h0, 32'h0, 1'h1, 3'h6, 32'h0);
      ev(2'h0, 32'h0, 4'h2, 32'h0000_1002, 2'h0, 8'h90);
      mv(2'h1, 32'h0000_0001, 1'h0, 3'h6, 32'h0);
      mv(2'h0, 32'h0, 1'h1, 3'h7, 32'h000D_0002);
      ev(2'h2, TRAP, 4'h2, 32'h0000_0FFE, 2'h3, 8'h90);
      ev(2'h0, 32'h0, 4'h2, 32'h0000_1004, 2'h0, 8'h90);
      mv(2'h0, 32'h0, 1'h1, 3'h7, 32'h000D_0001);
      ev(2'h2, TRAP, 4'h1, 32'h0, 2'h0, 8'h90);
      mv(2'h1, 32'h000D_0000, 1'h0, 3'h7, 32'h0);
      mv(2'h1, 32'h0000_8001, 1'h0, 3'h6, 32'h0);
      $display("test data breakpoints done");
      a = $urandom;
      mv(2'h0, 32'h0, 1'h1, 3'h1, a);
      mv(2'h0, 32'h0, 1'h1, 3'h7, 32'h0000_0008);
      ev(2'h2, FLT, 4'h8, a, 2'h0, 8'h90);
      u_dbgbp_core_model.st(1'h0, 1'h1);
      ev(2'h2, TRAP, 4'h4, 32'h0, 2'h0, 8'h90);
      u_dbgbp_core_model.st(1'h0, 1'h0);
      ev(2'h2, 32'h0000_0003, 4'h4, 32'h0, 2'h0, 8'hCC);
      mv(2'h0, 32'h0, 1'h1, 3'h7, 32'h0000_2000);
      mv(2'h2, FLT, 1'h0, 3'h0, 32'h0);
      mv(2'h1, 32'h0, 1'h0, 3'h7, 32'h0);
      mv(2'h1, 32'h0000_E003, 1'h0, 3'h6, 32'h0);
      $display("test exceptions done");
      // I/O and read/write types with extensions on, then a write-only type and a quiet task switch.
      mv(2'h0, 32'h0, 1'h1, 3'h1, 32'h0000_2000);
      u_dbgbp_core_model.st(1'h1, 1'h0);
      mv(2'h0, 32'h0, 1'h1, 3'h7, 32'h0072_0002);
      mv(2'h0, 32'h0, 1'h1, 3'h6, 32'h0);
      u_dbgbp_core_model.cyc(1'h0, 1'h1, 1'h0);
      ev(2'h2, TRAP, 4'h2, 32'h0000_1000, 2'h0, 8'h90);
      u_dbgbp_core_model.cyc(1'h0, 1'h0, 1'h0);
      ev(2'h0, 32'h0, 4'h2, 32'h0000_1000, 2'h0, 8'h90);
      ev(2'h0, 32'h0, 4'h2, 32'h0000_2001, 2'h0, 8'h90);
      mv(2'h1, 32'h0000_0003, 1'h0, 3'h6, 32'h0);
      mv(2'h0, 32'h0, 1'h1, 3'h7, 32'h0050_000C);
      ev(2'h0, 32'h0, 4'h2, 32'h0000_2000, 2'h0, 8'h90);
      u_dbgbp_core_model.cyc(1'h1, 1'h0, 1'h0);
      ev(2'h2, TRAP, 4'h2, 32'h0000_2000, 2'h1, 8'h90);
      ev(2'h0, 32'h0, 4'h1, 32'h0, 2'h0, 8'h90);
      mv(2'h1, 32'h0050_0008, 1'h0, 3'h7, 32'h0);
      mv(2'h1, 32'h0000_0003, 1'h0, 3'h6, 32'h0);
      u_dbgbp_core_model.st(1'h0, 1'h0);
      $display("test cycle types done");
      for (int k = 0; k < 20 && q.size() != 0; k++) @(negedge clk);
      if (q.size() != 0)
      begin
         $display("unexpected pending notes: expected 0 seen %0d", q.size());
         num_errors++;
      end
      summarize();
   end
endmodule
